// >>> hw/tsw_pkg.sv
// Constants, register offsets and types for the transceiver status word.
// Assumes a single 250 MHz core clock and a synchronous active-high reset.
//
// Behaviour
// R1 - In transmit mode bit 15 is set while the holding register accepts a byte.
// R2 - In receive mode bit 15 is set once fill count reaches the threshold.
// R3 - Bit 14 is set after a power-on reset has occurred.
// R4 - In transmit mode bit 13 flags holding register underrun or overwrite.
// R5 - In receive mode bit 13 flags a byte arriving at a full queue.
// R6 - Bit 12 is set when the wake-up timer overflows.
// R7 - Bit 11 is set on a falling edge of the external event pin.
// R8 - Event flags of bits 15 to 11 clear once the word has been read.
// R9 - A serial command starting with zero reads the word; writes start with one.
// R10 - Low four bits give the offset value, bit 4 its sign.
// R11 - Host should clear the offset enable before reading for a stable offset.
// R12 - All stored status bits are zero straight after power-on.
// R13 - Bit 9 is one while the receive queue is empty.
// R14 - Bit 5 toggles for every frequency control cycle run.
// R15 - Status word leaves most significant bit first, one bit per serial clock.
package tsw_pkg;

  // Widths
  localparam int STAT_W = 16;
  localparam int FILL_W = 5;
  localparam int THR_W  = 4;
  localparam int OFFS_W = 5;
  localparam int EV_W   = 5;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 4;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] ADDR_STATUS   = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_CONFIG   = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 4'h8;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 4'hc;

  // Config fields and reset values
  localparam int CFG_TXMODE_BIT = 0;
  localparam int CFG_THR_LSB    = 4;
  localparam int CFG_OFFSEN_BIT = 8;
  localparam logic [THR_W-1:0] CFG_THR_RST    = 4'h8;
  localparam logic             CFG_OFFSEN_RST = 1'b1;

  // Event flag indices, also irq status layout
  localparam int EV_READY = 4;
  localparam int EV_POR   = 3;
  localparam int EV_ERR   = 2;
  localparam int EV_WAKE  = 1;
  localparam int EV_EXT   = 0;

  // Status word bit positions
  localparam int ST_READY  = 15;
  localparam int ST_POR    = 14;
  localparam int ST_ERR    = 13;
  localparam int ST_WAKE   = 12;
  localparam int ST_EXT    = 11;
  localparam int ST_EMPTY  = 9;
  localparam int ST_AFCTOG = 5;

  // Serial command
  localparam logic CMD_READ_BIT = 1'b0;

  typedef enum logic [1:0] {
    SER_IDLE = 2'b00,
    SER_CMD  = 2'b01,
    SER_READ = 2'b10,
    SER_SKIP = 2'b11
  } tsw_ser_state_t;

endpackage : tsw_pkg

// >>> hw/tsw_ser_if.sv
// Carries the status word to the serial engine and its read-done pulse back.
// Assumes both ends run on core_clk.
`timescale 1ns/10ps
interface tsw_ser_if;
  logic [tsw_pkg::STAT_W-1:0] statWord;
  logic                       readDone;

  modport core (output statWord, input readDone);
  modport ser  (input statWord, output readDone);
endinterface : tsw_ser_if

// >>> hw/tsw_serial.sv
// Serial command engine: decodes the first bit and shifts the status word out.
// Assumes pins are asynchronous to core_clk and the serial clock is much slower.
`timescale 1ns/10ps
module tsw_serial (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic sys_rst,
  // Status word link
  tsw_ser_if.ser    link,
  // Serial pins
  input  wire logic serSelN,
  input  wire logic serClk,
  input  wire logic serDin,
  output logic      serDout,
  output logic      serDoutEn
);

  typedef struct packed {
    logic [2:0]                 sync1;
    logic [2:0]                 sync2;
    logic [2:0]                 prev;
    tsw_pkg::tsw_ser_state_t    fsm;
    logic                       loaded;
    logic [tsw_pkg::STAT_W-1:0] shift;
    logic                       done;
  } tsw_ser_reg_t;

  tsw_ser_reg_t st_reg;
  tsw_ser_reg_t st_next;
  logic         sckRise;
  logic         sckFall;
  logic         selected;

  // Edges taken from the second sync stage only, never the first
  always_comb begin
    st_next  = st_reg;
    selected = ~st_reg.sync2[2];
    sckRise  = st_reg.sync2[1] & ~st_reg.prev[1];
    sckFall  = ~st_reg.sync2[1] & st_reg.prev[1];
    st_next.sync1 = {serSelN, serClk, serDin};
    st_next.sync2 = st_reg.sync1;
    st_next.prev  = st_reg.sync2;
    st_next.done  = 1'b0;
    unique case (st_reg.fsm)
      tsw_pkg::SER_IDLE: begin
        st_next.loaded = 1'b0;
        if (selected) st_next.fsm = tsw_pkg::SER_CMD;
      end
      tsw_pkg::SER_CMD: begin
        if (!selected) begin
          st_next.fsm = tsw_pkg::SER_IDLE;
        end else if (sckRise) begin
          // First bit picks read or write command
          st_next.fsm = (st_reg.sync2[0] == tsw_pkg::CMD_READ_BIT) ?
                        tsw_pkg::SER_READ : tsw_pkg::SER_SKIP; // R9
        end
      end
      tsw_pkg::SER_READ: begin
        if (!selected) begin
          st_next.fsm  = tsw_pkg::SER_IDLE;
          st_next.done = st_reg.loaded; // A frame cut before the snapshot clears nothing
        end else if (sckFall) begin
          // Snapshot on first fall, then MSB first one bit per clock
          if (!st_reg.loaded) begin
            st_next.shift  = link.statWord; // R15
            st_next.loaded = 1'b1;
          end else begin
            st_next.shift = {st_reg.shift[tsw_pkg::STAT_W-2:0], 1'b0}; // R15
          end
        end
      end
      tsw_pkg::SER_SKIP: begin
        if (!selected) st_next.fsm = tsw_pkg::SER_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_reg      <= '0;
      st_reg.sync1 <= 3'h5; // Idle pins: select high, clock low, no false edge
      st_reg.sync2 <= 3'h5;
      st_reg.prev  <= 3'h5;
    end else begin
      st_reg <= st_next;
    end
  end

  assign serDout       = st_reg.shift[tsw_pkg::STAT_W-1];
  assign serDoutEn     = (st_reg.fsm == tsw_pkg::SER_READ);
  assign link.readDone = st_reg.done;

  property p_cmd_decode;
    @(posedge core_clk) disable iff (sys_rst)
    (st_reg.fsm == tsw_pkg::SER_CMD && selected && sckRise && !st_reg.sync2[0])
      |=> (st_reg.fsm == tsw_pkg::SER_READ);
  endproperty
  a_cmd_decode: assert property (p_cmd_decode) else $error("read command not decoded"); // R9

  property p_msb_first;
    @(posedge core_clk) disable iff (sys_rst)
    (st_reg.fsm == tsw_pkg::SER_READ && selected && sckFall && !st_reg.loaded)
      |=> (serDout == $past(link.statWord[tsw_pkg::STAT_W-1]));
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("status msb not first"); // R15

  c_read_frame: cover property (@(posedge core_clk) disable iff (sys_rst) st_reg.done);

endmodule : tsw_serial

// >>> hw/tsw_status_word.sv
// Status word of the radio transceiver: event flags, live bits, config and irq.
// Assumes radio event inputs are on core_clk; external pin and serial pins are not.
`timescale 1ns/10ps
module tsw_status_word (
  // Clock and reset
  input  wire logic                          core_clk,
  input  wire logic                          sys_rst,
  // Register port
  input  wire logic [tsw_pkg::ADDR_W-1:0]    regAddr,
  input  wire logic [tsw_pkg::DATA_W-1:0]    regWdata,
  input  wire logic                          regWr,
  input  wire logic                          regRd,
  output logic      [tsw_pkg::DATA_W-1:0]    regRdata,
  // Serial command pins
  input  wire logic                          serSelN,
  input  wire logic                          serClk,
  input  wire logic                          serDin,
  output logic                               serDout,
  output logic                               serDoutEn,
  // Transmit path
  input  wire logic                          txHoldFree,
  input  wire logic                          txUnderrun,
  // Receive path
  input  wire logic                          rxByteValid,
  input  wire logic                          rxFull,
  input  wire logic [tsw_pkg::FILL_W-1:0]    rxFillCount,
  // Misc radio state
  input  wire logic                          wakeupOverflow,
  input  wire logic                          externalEventPin,
  input  wire logic                          lowSupply,
  input  wire logic                          signalStrength,
  input  wire logic                          dataQuality,
  input  wire logic                          clockRecoveryLock,
  // Frequency control
  input  wire logic                          afcCycleDone,
  input  wire logic [tsw_pkg::OFFS_W-1:0]    afcOffset,
  output logic                               freqOffsetEnable,
  // Mode and interrupt
  output logic                               txMode,
  output logic                               irq
);

  typedef struct packed {
    logic [tsw_pkg::EV_W-1:0]   flags;
    logic                       porSeen;
    logic                       afcToggle;
    logic [tsw_pkg::OFFS_W-1:0] offsetHold;
    logic                       extS1;
    logic                       extS2;
    logic                       extLast;
    logic                       txMode;
    logic [tsw_pkg::THR_W-1:0]  thr;
    logic                       offsEn;
    logic [tsw_pkg::EV_W-1:0]   irqStat;
    logic [tsw_pkg::EV_W-1:0]   irqMask;
    logic [tsw_pkg::DATA_W-1:0] rdata;
  } tsw_core_reg_t;

  tsw_core_reg_t              st_reg;
  tsw_core_reg_t              st_next;
  logic [tsw_pkg::EV_W-1:0]   ev;
  logic [tsw_pkg::EV_W-1:0]   w1c;
  logic [tsw_pkg::STAT_W-1:0] statWord;
  logic                       clr;
  logic                       readyCond;
  logic                       errEv;
  logic                       extEv;
  logic                       rxEmpty;

  tsw_ser_if serLink ();

  // Serial engine owns the pins and reports the end of a read frame
  tsw_serial u_serial (
    .core_clk  (core_clk),
    .sys_rst   (sys_rst),
    .link      (serLink.ser),
    .serSelN   (serSelN),
    .serClk    (serClk),
    .serDin    (serDin),
    .serDout   (serDout),
    .serDoutEn (serDoutEn)
  );

  // Event detection and word assembly
  always_comb begin
    rxEmpty   = (rxFillCount == '0); // R13
    readyCond = st_reg.txMode ? txHoldFree                  // R1
              : (rxFillCount >= {1'b0, st_reg.thr});        // R2
    errEv     = st_reg.txMode ? txUnderrun                  // R4
              : (rxByteValid & rxFull);                     // R5
    extEv     = st_reg.extLast & ~st_reg.extS2;             // R7
    ev                   = '0;
    ev[tsw_pkg::EV_READY] = readyCond;
    ev[tsw_pkg::EV_POR]   = ~st_reg.porSeen;                // R3
    ev[tsw_pkg::EV_ERR]   = errEv;
    ev[tsw_pkg::EV_WAKE]  = wakeupOverflow;                 // R6
    ev[tsw_pkg::EV_EXT]   = extEv;
    // Offset sign sits above the four value bits
    statWord = {st_reg.flags, lowSupply, rxEmpty, signalStrength,
                dataQuality, clockRecoveryLock, st_reg.afcToggle,
                st_reg.offsetHold}; // R10
  end

  assign serLink.statWord = statWord;

  // Clear source: serial read frame end or register read of the word
  always_comb begin
    clr = serLink.readDone
        | (regRd && regAddr == tsw_pkg::ADDR_STATUS); // R8
    w1c = '0;
    if (regWr && regAddr == tsw_pkg::ADDR_IRQ_STAT) begin
      w1c = regWdata[tsw_pkg::EV_W-1:0];
    end
  end

  // Next-state logic; every set beats a clear in the same cycle
  always_comb begin
    st_next         = st_reg;
    st_next.porSeen = 1'b1;
    st_next.flags   = ev | (st_reg.flags & ~{tsw_pkg::EV_W{clr}}); // R8
    st_next.irqStat = ev | (st_reg.irqStat & ~w1c);
    // Pin synchroniser; only extS2 feeds the edge detector
    st_next.extS1   = externalEventPin;
    st_next.extS2   = st_reg.extS1;
    st_next.extLast = st_reg.extS2;
    if (afcCycleDone) begin
      st_next.afcToggle = ~st_reg.afcToggle; // R14
    end
    // Offset frozen while disabled so a read sees a stable value
    if (st_reg.offsEn) begin
      st_next.offsetHold = afcOffset; // R10
    end
    if (regWr) begin
      unique case (regAddr)
        tsw_pkg::ADDR_CONFIG: begin
          st_next.txMode = regWdata[tsw_pkg::CFG_TXMODE_BIT];
          st_next.thr    = regWdata[tsw_pkg::CFG_THR_LSB +: tsw_pkg::THR_W];
          st_next.offsEn = regWdata[tsw_pkg::CFG_OFFSEN_BIT];
        end
        tsw_pkg::ADDR_IRQ_MASK: begin
          st_next.irqMask = regWdata[tsw_pkg::EV_W-1:0];
        end
        default: begin
          st_next.irqMask = st_reg.irqMask;
        end
      endcase
    end
    // Read data only in the cycle after the strobe; unmapped reads give zero
    st_next.rdata = '0;
    if (regRd) begin
      unique case (regAddr)
        tsw_pkg::ADDR_STATUS: begin
          st_next.rdata[tsw_pkg::STAT_W-1:0] = statWord;
        end
        tsw_pkg::ADDR_CONFIG: begin
          st_next.rdata[tsw_pkg::CFG_TXMODE_BIT] = st_reg.txMode;
          st_next.rdata[tsw_pkg::CFG_THR_LSB +: tsw_pkg::THR_W] = st_reg.thr;
          st_next.rdata[tsw_pkg::CFG_OFFSEN_BIT] = st_reg.offsEn;
        end
        tsw_pkg::ADDR_IRQ_STAT: begin
          st_next.rdata[tsw_pkg::EV_W-1:0] = st_reg.irqStat;
        end
        tsw_pkg::ADDR_IRQ_MASK: begin
          st_next.rdata[tsw_pkg::EV_W-1:0] = st_reg.irqMask;
        end
        default: begin
          st_next.rdata = '0;
        end
      endcase
    end
  end

  // State register; flags start clear, pin sync idles high
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_reg         <= '0; // R12
      st_reg.extS1   <= 1'b1;
      st_reg.extS2   <= 1'b1;
      st_reg.extLast <= 1'b1;
      st_reg.thr     <= tsw_pkg::CFG_THR_RST;
      st_reg.offsEn  <= tsw_pkg::CFG_OFFSEN_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs
  assign regRdata         = st_reg.rdata;
  assign txMode           = st_reg.txMode;
  assign freqOffsetEnable = st_reg.offsEn;
  assign irq              = |(st_reg.irqStat & st_reg.irqMask);

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  property p_tx_ready;
    (st_reg.txMode && txHoldFree) |=> statWord[tsw_pkg::ST_READY];
  endproperty
  a_tx_ready: assert property (p_tx_ready) else $error("tx ready not flagged"); // R1

  property p_rx_level;
    (!st_reg.txMode && rxFillCount >= {1'b0, st_reg.thr})
      |=> statWord[tsw_pkg::ST_READY];
  endproperty
  a_rx_level: assert property (p_rx_level) else $error("fill level not flagged"); // R2

  property p_por;
    $rose(st_reg.porSeen) |-> statWord[tsw_pkg::ST_POR];
  endproperty
  a_por: assert property (p_por) else $error("power-on flag missing"); // R3

  property p_tx_err;
    (st_reg.txMode && txUnderrun) |=> statWord[tsw_pkg::ST_ERR];
  endproperty
  a_tx_err: assert property (p_tx_err) else $error("underrun not flagged"); // R4

  property p_rx_ovf;
    (!st_reg.txMode && rxByteValid && rxFull) |=> statWord[tsw_pkg::ST_ERR];
  endproperty
  a_rx_ovf: assert property (p_rx_ovf) else $error("overflow not flagged"); // R5

  property p_wake;
    wakeupOverflow |=> statWord[tsw_pkg::ST_WAKE];
  endproperty
  a_wake: assert property (p_wake) else $error("wake-up flag missing"); // R6

  property p_ext_edge;
    $fell(st_reg.extS2) |=> statWord[tsw_pkg::ST_EXT];
  endproperty
  a_ext_edge: assert property (p_ext_edge) else $error("pin edge missed"); // R7

  property p_clear;
    (clr && ev == '0) |=> (st_reg.flags == '0);
  endproperty
  a_clear: assert property (p_clear) else $error("flags not cleared"); // R8

  property p_offset;
    (st_reg.offsEn && !sys_rst) |=> (statWord[tsw_pkg::OFFS_W-1:0] == $past(afcOffset));
  endproperty
  a_offset: assert property (p_offset) else $error("offset not reported"); // R10

  property p_reset_zero;
    @(posedge core_clk) disable iff (1'b0)
    sys_rst |=> (st_reg.flags == '0 && !st_reg.afcToggle);
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("flags not zero"); // R12

  property p_empty;
    statWord[tsw_pkg::ST_EMPTY] == (rxFillCount == '0);
  endproperty
  a_empty: assert property (p_empty) else $error("empty bit wrong"); // R13

  property p_afc_toggle;
    afcCycleDone |=> (statWord[tsw_pkg::ST_AFCTOG] != $past(st_reg.afcToggle));
  endproperty
  a_afc_toggle: assert property (p_afc_toggle) else $error("afc bit not toggled"); // R14

  // Quiet flags: with no event, a clear or an already low flag leaves the flag low next cycle
  property p_tx_not_ready;
    (st_reg.txMode && !txHoldFree && clr) |=> !statWord[tsw_pkg::ST_READY];
  endproperty
  a_tx_not_ready: assert property (p_tx_not_ready) else $error("tx ready stuck"); // R1

  property p_rx_below;
    (!st_reg.txMode && rxFillCount < {1'b0, st_reg.thr} && !statWord[tsw_pkg::ST_READY])
      |=> !statWord[tsw_pkg::ST_READY];
  endproperty
  a_rx_below: assert property (p_rx_below) else $error("fill level flag early"); // R2

  property p_por_once;
    (st_reg.porSeen && clr) |=> !statWord[tsw_pkg::ST_POR];
  endproperty
  a_por_once: assert property (p_por_once) else $error("power-on flag stuck"); // R3

  property p_err_quiet;
    (!errEv && clr) |=> !statWord[tsw_pkg::ST_ERR];
  endproperty
  a_err_quiet: assert property (p_err_quiet) else $error("error flag stuck"); // R4

  property p_wake_quiet;
    (!wakeupOverflow && clr) |=> !statWord[tsw_pkg::ST_WAKE];
  endproperty
  a_wake_quiet: assert property (p_wake_quiet) else $error("wake-up flag stuck"); // R6

  property p_ext_quiet;
    (!extEv && clr) |=> !statWord[tsw_pkg::ST_EXT];
  endproperty
  a_ext_quiet: assert property (p_ext_quiet) else $error("pin edge flag stuck"); // R7

  // Serial frame end clears the flags; register read of the word returns it
  property p_serial_clear;
    (serLink.readDone && ev == '0) |=> (st_reg.flags == '0);
  endproperty
  a_serial_clear: assert property (p_serial_clear) else $error("serial read left flags"); // R8

  property p_status_read;
    (regRd && regAddr == tsw_pkg::ADDR_STATUS)
      |=> (regRdata[tsw_pkg::STAT_W-1:0] == $past(statWord));
  endproperty
  a_status_read: assert property (p_status_read) else $error("status word read wrong"); // R10

  c_serial_clear: cover property (serLink.readDone && st_reg.flags != '0);
  c_irq_raise:    cover property (!irq ##1 irq);
  c_ext_edge:     cover property ($fell(st_reg.extS2));

endmodule : tsw_status_word

// >>> sim/tsw_host_model.sv
// Host controller model: frames serial commands on the select, clock and data pins.
// Assumes core_clk as its time base; the serial clock stands low outside frames.
`timescale 1ns/10ps
module tsw_host_model (
  // Time base
  input  wire logic core_clk,
  // Serial pins
  output logic      serSelN,
  output logic      serClk,
  output logic      serDin,
  input  wire logic serDout,
  input  wire logic serDoutEn
);
  // Half period of the serial clock in core cycles, well above the 4 needed
  localparam int HALF = 8;

  initial begin
    serSelN = 1'b1;
    serClk  = 1'b0;
    serDin  = 1'b1;
  end

  // One frame: first bit picks the command, then 16 clocks gather the reply
  task automatic frame(input logic firstBit, output logic [15:0] word, output int enSeen);
    enSeen = 0;
    @(posedge core_clk) serSelN <= 1'b0;
    repeat (HALF) @(posedge core_clk);
    serDin <= firstBit;
    serClk <= 1'b1;
    repeat (HALF) @(posedge core_clk);
    // Sampled just before each rise, long after the falling edge shifted
    for (int i = 15; i >= 0; i--) begin
      serClk <= 1'b0;
      repeat (HALF) @(posedge core_clk);
      word[i] = serDout;
      if (serDoutEn === 1'b1) begin
        enSeen++;
      end
      serClk <= 1'b1;
      repeat (HALF) @(posedge core_clk);
    end
    serClk <= 1'b0;
    repeat (HALF) @(posedge core_clk);
    serSelN <= 1'b1;
    // Released data line shows the inverse, not a stale value
    serDin <= ~firstBit;
    repeat (HALF) @(posedge core_clk);
  endtask : frame
endmodule : tsw_host_model

// >>> sim/test_tsw_status_word.sv
// Self-checking bench for the status word: register port, events, irq and serial read.
// Assumes the host model drives the serial pins; everything else is driven here.
`timescale 1ns/10ps
module test_tsw_status_word;
  localparam int CYCLE_LIMIT = 20000;

  logic                           core_clk;
  logic                           sys_rst;
  logic [tsw_pkg::ADDR_W-1:0]     regAddr;
  logic [tsw_pkg::DATA_W-1:0]     regWdata;
  logic                           regWr;
  logic                           regRd;
  logic [tsw_pkg::DATA_W-1:0]     regRdata;
  logic                           serSelN;
  logic                           serClk;
  logic                           serDin;
  logic                           serDout;
  logic                           serDoutEn;
  logic                           txHoldFree;
  logic                           txUnderrun;
  logic                           rxByteValid;
  logic                           rxFull;
  logic [tsw_pkg::FILL_W-1:0]     rxFillCount;
  logic                           wakeupOverflow;
  logic                           externalEventPin;
  logic                           lowSupply;
  logic                           signalStrength;
  logic                           dataQuality;
  logic                           clockRecoveryLock;
  logic                           afcCycleDone;
  logic [tsw_pkg::OFFS_W-1:0]     afcOffset;
  logic                           freqOffsetEnable;
  logic                           txMode;
  logic                           irq;
  int                             fail_count;
  int                             samples_checked;
  int                             cycleCount;
  logic [15:0]                    serWord;
  int                             enSeen;

  tsw_status_word u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .serSelN(serSelN), .serClk(serClk), .serDin(serDin), .serDout(serDout),
    .serDoutEn(serDoutEn), .txHoldFree(txHoldFree), .txUnderrun(txUnderrun),
    .rxByteValid(rxByteValid), .rxFull(rxFull), .rxFillCount(rxFillCount),
    .wakeupOverflow(wakeupOverflow), .externalEventPin(externalEventPin),
    .lowSupply(lowSupply), .signalStrength(signalStrength), .dataQuality(dataQuality),
    .clockRecoveryLock(clockRecoveryLock), .afcCycleDone(afcCycleDone),
    .afcOffset(afcOffset), .freqOffsetEnable(freqOffsetEnable), .txMode(txMode), .irq(irq));

  tsw_host_model u_host (.core_clk(core_clk), .serSelN(serSelN), .serClk(serClk),
    .serDin(serDin), .serDout(serDout), .serDoutEn(serDoutEn));

  // Free-running core clock
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // Hang guard: a stuck run still reaches the verdict
  always @(posedge core_clk) begin
    cycleCount <= cycleCount + 1;
    if (cycleCount == CYCLE_LIMIT) begin
      fail_count++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // One-cycle write strobe
  task automatic regWrite(input logic [3:0] addr, input logic [31:0] data);
    @(posedge core_clk) begin
      regWr    <= 1'b1;
      regAddr  <= addr;
      regWdata <= data;
    end
    @(posedge core_clk) regWr <= 1'b0;
  endtask : regWrite

  // Read strobe, data taken in the cycle after the one it stands
  task automatic rdChk(input logic [3:0] addr, input logic [31:0] exp);
    @(posedge core_clk) begin
      regRd   <= 1'b1;
      regAddr <= addr;
    end
    @(posedge core_clk) regRd <= 1'b0;
    #1 check(regRdata, exp);
  endtask : rdChk

  // Single-cycle event pulse by index
  task automatic pulse(input int k);
    @(posedge core_clk) begin
      wakeupOverflow <= (k == 0);
      rxByteValid    <= (k == 1);
      txUnderrun     <= (k == 2);
      afcCycleDone   <= (k == 3);
    end
    @(posedge core_clk) begin
      wakeupOverflow <= 1'b0;
      rxByteValid    <= 1'b0;
      txUnderrun     <= 1'b0;
      afcCycleDone   <= 1'b0;
    end
  endtask : pulse

  // Falling then rising edge on the async pin, with sync time
  task automatic pinFall();
    @(posedge core_clk) externalEventPin <= 1'b0;
    repeat (6) @(posedge core_clk);
    externalEventPin <= 1'b1;
    repeat (6) @(posedge core_clk);
  endtask : pinFall

  initial begin
    fail_count = 0; samples_checked = 0; cycleCount = 0;
    regAddr = 4'h0; regWdata = 32'h0; regWr = 1'b0; regRd = 1'b0;
    txHoldFree = 1'b0; txUnderrun = 1'b0; rxByteValid = 1'b0; rxFull = 1'b0;
    rxFillCount = 5'h00; wakeupOverflow = 1'b0; externalEventPin = 1'b1;
    lowSupply = 1'b0; signalStrength = 1'b0; dataQuality = 1'b0;
    clockRecoveryLock = 1'b0; afcCycleDone = 1'b0; afcOffset = 5'h00;
    sys_rst = 1'b1;
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    // Reset values, power-on flag and its clear on read
    rdChk(4'h0, 32'h00004200);
    rdChk(4'h0, 32'h00000200);
    rdChk(4'h4, 32'h00000180);
    rdChk(4'hc, 32'h00000000);
    rdChk(4'h2, 32'h00000000);
    check({31'h0, irq}, 32'h0);
    // Serial read returns MSB first and clears flags; a write-type frame does not
    pulse(0);
    u_host.frame(1'b0, serWord, enSeen);
    check({16'h0, serWord}, 32'h00001200);
    check(enSeen, 32'd16);
    rdChk(4'h0, 32'h00000200);
    pulse(0);
    u_host.frame(1'b1, serWord, enSeen);
    check(enSeen, 32'd0);
    rdChk(4'h0, 32'h00001200);
    // Receive mode: threshold 3, overflow, wake, edge, fill boundary
    regWrite(4'h4, 32'h00000130);
    rxFull <= 1'b1;
    pulse(1);
    pulse(0);
    pinFall();
    rxFillCount <= 5'h03;
    rdChk(4'h0, 32'h0000b800);
    rxFillCount <= 5'h02;
    rdChk(4'h0, 32'h00008000);
    rdChk(4'h0, 32'h00000000);
    rxFillCount <= 5'h00;
    rxFull <= 1'b0;
    // Transmit mode: ready level and underrun
    regWrite(4'h4, 32'h00000131);
    txHoldFree <= 1'b1;
    #1 check({31'h0, txMode}, 32'h1);
    pulse(2);
    rdChk(4'h0, 32'h0000a200);
    txHoldFree <= 1'b0;
    rdChk(4'h0, 32'h00008200);
    rdChk(4'h0, 32'h00000200);
    // Interrupt: clear, mask, raise, clear one bit
    regWrite(4'h4, 32'h00000130);
    regWrite(4'h8, 32'h0000001f);
    regWrite(4'hc, 32'h00000002);
    rdChk(4'h8, 32'h00000000);
    check({31'h0, irq}, 32'h0);
    pulse(0);
    #1 check({31'h0, irq}, 32'h1);
    rdChk(4'h8, 32'h00000002);
    pinFall();
    rdChk(4'h8, 32'h00000003);
    regWrite(4'h8, 32'h00000002);
    @(posedge core_clk);
    #1 check({31'h0, irq}, 32'h0);
    rdChk(4'h8, 32'h00000001);
    rdChk(4'hc, 32'h00000002);
    // Live bits, offset value and sign, cycle toggle, frozen offset
    rdChk(4'h0, 32'h00001a00);
    lowSupply <= 1'b1; signalStrength <= 1'b1;
    dataQuality <= 1'b1; clockRecoveryLock <= 1'b1;
    afcOffset <= 5'h1b;
    pulse(3);
    rdChk(4'h0, 32'h000007fb);
    regWrite(4'h4, 32'h00000030);
    afcOffset <= 5'h05;
    #1 check({31'h0, freqOffsetEnable}, 32'h0);
    pulse(3);
    rdChk(4'h0, 32'h000007db);
    regWrite(4'h2, 32'h000001ff);
    regWrite(4'h0, 32'h0000ffff);
    rdChk(4'h4, 32'h00000030);
    rdChk(4'h0, 32'h000007db);
    // Mid-run reset: power-on flag again, toggle and config back to reset
    @(posedge core_clk) sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    rdChk(4'h0, 32'h000047c5);
    rdChk(4'h4, 32'h00000180);
    give_verdict();
  end
endmodule : test_tsw_status_word
